// >>> mcc_pkg.sv
package mcc_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] ACC_B3_ADDR  = 8'h40;
  localparam logic [7:0] ACC_B2_ADDR  = 8'h41;
  localparam logic [7:0] ACC_B1_ADDR  = 8'h42;
  localparam logic [7:0] ACC_B0_ADDR  = 8'h43;
  localparam logic [7:0] CTRL_ADDR    = 8'h44;
  localparam logic [7:0] OPA_HI_ADDR  = 8'h45;
  localparam logic [7:0] OPA_LO_ADDR  = 8'h46;
  localparam logic [7:0] OPB_HI_ADDR  = 8'h47;
  localparam logic [7:0] OPB_LO_ADDR  = 8'h48;
  localparam logic [7:0] STAT_ADDR    = 8'h49;

  // ************************************************************
  // field positions, reset values, timing
  // ************************************************************
  localparam int          CTRL_SIG_BIT  = 7;
  localparam int          CTRL_DIV_BIT  = 6;
  localparam int          CTRL_MAC_BIT  = 5;
  localparam int          CTRL_DCC_BIT  = 4;
  localparam int          CTRL_TRG_BIT  = 3;
  localparam int          STAT_NEG_BIT  = 7;
  localparam int          STAT_RZF_BIT  = 6;
  localparam int          STAT_OVF_BIT  = 2;
  localparam int          STAT_DZF_BIT  = 1;
  localparam int          STAT_ACF_BIT  = 0;
  localparam logic [7:0]  STAT_RESET    = 8'h00;
  localparam logic [7:0]  RDATA_RESET   = 8'h00;
  localparam logic [3:0]  OP_CYCLES     = 4'h8;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mcc_bus_req_t;

  typedef struct packed {
    logic signed_select;
    logic divide_select;
    logic accumulate_select;
    logic quotient_compensation_select;
  } mcc_ctrl_t;

  typedef struct packed {
    logic negative_result_flag;
    logic remainder_zero_flag;
    logic overflow_flag;
    logic divide_by_zero_flag;
    logic completion_flag;
  } mcc_flags_t;

  localparam mcc_ctrl_t  CTRL_RESET  = '0;
  localparam mcc_flags_t FLAGS_RESET = '0;

endpackage

// >>> mcc_top.sv
`timescale 1ns/100ps
module mcc_top
  import mcc_pkg::*;
(
  input  wire logic         clock_in,
  input  wire logic         rst_in,
  input  wire mcc_bus_req_t bus_in,
  output logic [7:0]        rdata_out,
  output logic              busy_out
);

  // ************************************************************
  // state
  // ************************************************************
  mcc_ctrl_t   ctrl,     next_ctrl;
  mcc_flags_t  flags,    next_flags;
  logic [15:0] operand_a, next_operand_a;
  logic [15:0] operand_b, next_operand_b;
  logic [31:0] accumulator_32, next_accumulator_32;
  logic [3:0]  cnt,      next_cnt;
  logic        busy,     next_busy;
  logic [7:0]  rdata,    next_rdata;

  // ************************************************************
  // decode of host accesses
  // ************************************************************
  logic wr_ctrl, wr_stat, wr_a_lo, wr_b_lo, trg_set, start, done;

  always_comb begin
    wr_ctrl = bus_in.wr && (bus_in.addr == CTRL_ADDR);
    wr_stat = bus_in.wr && (bus_in.addr == STAT_ADDR);
    wr_a_lo = bus_in.wr && (bus_in.addr == OPA_LO_ADDR);
    wr_b_lo = bus_in.wr && (bus_in.addr == OPB_LO_ADDR);
    // trigger uses the control value that the host is writing now
    trg_set = wr_ctrl && bus_in.wdata[CTRL_TRG_BIT];
    start   = trg_set
            || (wr_b_lo && !ctrl.divide_select)
            || (wr_a_lo && ctrl.divide_select && !ctrl.accumulate_select);
    done    = busy && (cnt == 4'h1);
  end

  // ************************************************************
  // arithmetic, evaluated on the completing cycle
  // ************************************************************
  logic        sg;
  logic [31:0] prod, a_ext, q32, r32, acc_res;
  logic [32:0] mac_sum;
  logic [15:0] b_res;
  logic        ovf_ev, dzf_ev, neg_ev, rzf_ev, dz;

  // twos complement when the signed select is set
  always_comb begin
    sg      = ctrl.signed_select;
    a_ext   = sg ? {{16{operand_a[15]}}, operand_a} : {16'h0000, operand_a};
    prod    = sg ? 32'($signed(operand_a) * $signed(operand_b)) : 32'(operand_a * operand_b);
    mac_sum = {1'b0, accumulator_32} + {1'b0, prod};
    dz      = (operand_a == 16'h0000);
    q32     = 32'h0000_0000;
    r32     = 32'h0000_0000;
    acc_res = accumulator_32;
    b_res   = operand_b;
    ovf_ev  = 1'b0;
    dzf_ev  = 1'b0;
    neg_ev  = 1'b0;
    rzf_ev  = 1'b0;
    if (!ctrl.divide_select) begin
      // multiply: product into the accumulator; compensation ignored
      if (ctrl.accumulate_select) begin
        acc_res = mac_sum[31:0];
        ovf_ev  = sg ? ((accumulator_32[31] == prod[31]) && (mac_sum[31] != accumulator_32[31]))
                     : mac_sum[32];
      end else begin
        acc_res = prod;
      end
      neg_ev = sg && acc_res[31];
    end else if (dz) begin
      // zero divisor leaves every data register untouched
      dzf_ev = 1'b1;
    end else begin
      if (!ctrl.accumulate_select) begin
        // integer divide: dividend is the whole accumulator
        q32 = sg ? 32'($signed(accumulator_32) / $signed(a_ext)) : accumulator_32 / a_ext;
        r32 = sg ? 32'($signed(accumulator_32) % $signed(a_ext)) : accumulator_32 % a_ext;
        ovf_ev = sg && (accumulator_32 == 32'h8000_0000) && (operand_a == 16'hFFFF);
      end else begin
        // fractional divide: low half scaled up by sixteen bits
        q32 = sg ? 32'($signed({accumulator_32[15:0], 16'h0000}) / $signed(a_ext))
                 : {accumulator_32[15:0], 16'h0000} / a_ext;
        r32 = sg ? 32'($signed({accumulator_32[15:0], 16'h0000}) % $signed(a_ext))
                 : {accumulator_32[15:0], 16'h0000} % a_ext;
        // quotient must fit the low half
        ovf_ev = sg ? (q32[31:15] != {17{q32[15]}}) : (q32[31:16] != 16'h0000);
      end
      // keep the remainder non-negative so quotients can be chained
      if (sg && ctrl.quotient_compensation_select && r32[31]) begin
        q32 = operand_a[15] ? q32 + 32'h0000_0001 : q32 - 32'h0000_0001;
        r32 = operand_a[15] ? r32 - a_ext : r32 + a_ext;
      end
      b_res  = r32[15:0];
      rzf_ev = (r32[15:0] == 16'h0000);
      if (ctrl.accumulate_select) begin
        acc_res = {accumulator_32[15:0], q32[15:0]};
        neg_ev  = sg && q32[15];
      end else begin
        acc_res = q32;
        neg_ev  = sg && q32[31];
      end
    end
  end

  // ************************************************************
  // sequencer: fixed latency, a new start restarts the count
  // ************************************************************
  always_comb begin
    next_busy = busy;
    next_cnt  = cnt;
    if (start) begin
      next_busy = 1'b1;
      next_cnt  = OP_CYCLES;
    end else if (done) begin
      next_busy = 1'b0;
      next_cnt  = 4'h0;
    end else if (busy) begin
      next_cnt = cnt - 4'h1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      busy <= 1'b0;
      cnt  <= 4'h0;
    end else begin
      busy <= next_busy;
      cnt  <= next_cnt;
    end
  end

  // ************************************************************
  // control and status registers
  // ************************************************************
  always_comb begin
    next_ctrl  = ctrl;
    next_flags = flags;
    if (wr_ctrl) begin
      // trigger and low three bits are not stored
      next_ctrl = bus_in.wdata[CTRL_SIG_BIT:CTRL_DCC_BIT];
    end
    // write-one clears first, so a same-cycle event still lands
    if (wr_stat) begin
      if (bus_in.wdata[STAT_OVF_BIT]) next_flags.overflow_flag = 1'b0;
      if (bus_in.wdata[STAT_DZF_BIT]) next_flags.divide_by_zero_flag = 1'b0;
      if (bus_in.wdata[STAT_ACF_BIT]) next_flags.completion_flag = 1'b0;
    end
    if (done) begin
      next_flags.completion_flag      = 1'b1;
      next_flags.negative_result_flag = neg_ev;
      next_flags.remainder_zero_flag  = rzf_ev;
      if (ovf_ev) next_flags.overflow_flag = 1'b1;
      if (dzf_ev) next_flags.divide_by_zero_flag = 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl  <= CTRL_RESET;
      flags <= FLAGS_RESET;
    end else begin
      ctrl  <= next_ctrl;
      flags <= next_flags;
    end
  end

  // ************************************************************
  // data registers, deliberately without reset
  // ************************************************************
  // results win over a host byte write in the completing cycle
  always_comb begin
    next_operand_a      = operand_a;
    next_operand_b      = operand_b;
    next_accumulator_32 = accumulator_32;
    if (bus_in.wr) begin
      unique case (bus_in.addr)
        ACC_B3_ADDR: next_accumulator_32[31:24] = bus_in.wdata;
        ACC_B2_ADDR: next_accumulator_32[23:16] = bus_in.wdata;
        ACC_B1_ADDR: next_accumulator_32[15:8]  = bus_in.wdata;
        ACC_B0_ADDR: next_accumulator_32[7:0]   = bus_in.wdata;
        OPA_HI_ADDR: next_operand_a[15:8]       = bus_in.wdata;
        OPA_LO_ADDR: next_operand_a[7:0]        = bus_in.wdata;
        OPB_HI_ADDR: next_operand_b[15:8]       = bus_in.wdata;
        OPB_LO_ADDR: next_operand_b[7:0]        = bus_in.wdata;
        default: ;
      endcase
    end
    if (done) begin
      next_accumulator_32 = acc_res;
      next_operand_b      = b_res;
    end
  end

  always_ff @(posedge clock_in) begin
    operand_a      <= next_operand_a;
    operand_b      <= next_operand_b;
    accumulator_32 <= next_accumulator_32;
  end

  // ************************************************************
  // read port, one cycle after the read strobe
  // ************************************************************
  always_comb begin
    next_rdata = rdata;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        ACC_B3_ADDR: next_rdata = accumulator_32[31:24];
        ACC_B2_ADDR: next_rdata = accumulator_32[23:16];
        ACC_B1_ADDR: next_rdata = accumulator_32[15:8];
        ACC_B0_ADDR: next_rdata = accumulator_32[7:0];
        CTRL_ADDR:   next_rdata = {ctrl, 4'h0};
        OPA_HI_ADDR: next_rdata = operand_a[15:8];
        OPA_LO_ADDR: next_rdata = operand_a[7:0];
        OPB_HI_ADDR: next_rdata = operand_b[15:8];
        OPB_LO_ADDR: next_rdata = operand_b[7:0];
        STAT_ADDR:   next_rdata = {flags.negative_result_flag, flags.remainder_zero_flag, 3'h0,
                                   flags.overflow_flag, flags.divide_by_zero_flag, flags.completion_flag};
        default:     next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata <= RDATA_RESET;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign rdata_out = rdata;
  assign busy_out  = busy;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  property p_trg_reads_zero;
    bus_in.rd && (bus_in.addr == CTRL_ADDR) |=> (rdata_out[3:0] == 4'h0);
  endproperty
  a_trg_reads_zero: assert property (p_trg_reads_zero) else $error("control low bits not zero");

  property p_stat_reserved;
    bus_in.rd && (bus_in.addr == STAT_ADDR) |=> (rdata_out[5:3] == 3'h0);
  endproperty
  a_stat_reserved: assert property (p_stat_reserved) else $error("status reserved bits not zero");

  property p_mul_start;
    wr_b_lo && !ctrl.divide_select |=> busy_out && (cnt == OP_CYCLES);
  endproperty
  a_mul_start: assert property (p_mul_start) else $error("multiply did not start");

  property p_integer_divide_function_start;
    wr_a_lo && ctrl.divide_select && !ctrl.accumulate_select |=> busy_out ##[1:8] flags.completion_flag;
  endproperty
  a_integer_divide_function_start: assert property (p_integer_divide_function_start) else $error("divide did not start");

  property p_fractional_divide_function_no_write_start;
    !busy && wr_a_lo && ctrl.divide_select && ctrl.accumulate_select && !trg_set |=> !busy_out;
  endproperty
  a_fractional_divide_function_no_write_start: assert property (p_fractional_divide_function_no_write_start) else $error("divide started by write");

  property p_latency;
    start ##1 (!start) [*8] |=> !busy_out && flags.completion_flag;
  endproperty
  a_latency: assert property (p_latency) else $error("operation latency wrong");

  property p_acf_sticky;
    flags.completion_flag && !(wr_stat && bus_in.wdata[STAT_ACF_BIT]) |=> flags.completion_flag;
  endproperty
  a_acf_sticky: assert property (p_acf_sticky) else $error("completion flag lost");

  property p_ovf_clear;
    wr_stat && bus_in.wdata[STAT_OVF_BIT] && !done |=> !flags.overflow_flag;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

  property p_neg_readonly;
    wr_stat && !done |=> flags.negative_result_flag == $past(flags.negative_result_flag);
  endproperty
  a_neg_readonly: assert property (p_neg_readonly) else $error("negative flag changed by write");

  property p_dzf_set;
    done && ctrl.divide_select && (operand_a == 16'h0000) |=> flags.divide_by_zero_flag;
  endproperty
  a_dzf_set: assert property (p_dzf_set) else $error("divide by zero not flagged");

  property p_trg_zero_idle;
    wr_ctrl && !bus_in.wdata[CTRL_TRG_BIT] && !busy |=> !busy_out;
  endproperty
  a_trg_zero_idle: assert property (p_trg_zero_idle) else $error("zero trigger started work");

  property p_trg_start;
    trg_set |=> busy_out && (cnt == OP_CYCLES);
  endproperty
  a_trg_start: assert property (p_trg_start) else $error("trigger did not start");

  property p_ovf_sticky;
    flags.overflow_flag && !(wr_stat && bus_in.wdata[STAT_OVF_BIT]) |=> flags.overflow_flag;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");

  property p_dzf_sticky;
    flags.divide_by_zero_flag && !(wr_stat && bus_in.wdata[STAT_DZF_BIT]) |=> flags.divide_by_zero_flag;
  endproperty
  a_dzf_sticky: assert property (p_dzf_sticky) else $error("divide by zero flag lost");

  property p_dzf_clear;
    wr_stat && bus_in.wdata[STAT_DZF_BIT] && !done |=> !flags.divide_by_zero_flag;
  endproperty
  a_dzf_clear: assert property (p_dzf_clear) else $error("divide by zero flag not cleared");

  property p_acf_clear;
    wr_stat && bus_in.wdata[STAT_ACF_BIT] && !done |=> !flags.completion_flag;
  endproperty
  a_acf_clear: assert property (p_acf_clear) else $error("completion flag not cleared");

  property p_rzf_mul;
    done && !ctrl.divide_select |=> !flags.remainder_zero_flag;
  endproperty
  a_rzf_mul: assert property (p_rzf_mul) else $error("remainder flag set by multiply");

  property p_neg_unsigned;
    done && !ctrl.signed_select |=> !flags.negative_result_flag;
  endproperty
  a_neg_unsigned: assert property (p_neg_unsigned) else $error("negative flag in unsigned mode");

  property p_done_idle;
    done && !start |=> !busy_out && (cnt == 4'h0);
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("busy after completion");

  property p_opa_kept;
    done && !(bus_in.wr && ((bus_in.addr == OPA_HI_ADDR) || (bus_in.addr == OPA_LO_ADDR))) |=> $stable(operand_a);
  endproperty
  a_opa_kept: assert property (p_opa_kept) else $error("operand_a changed by operation");

endmodule

// >>> mcc_host_model.sv
`timescale 1ns/100ps
module mcc_host_model
  import mcc_pkg::*;
(
  input  wire logic         clock_in,
  input  wire logic [7:0]   rdata_in,
  output mcc_bus_req_t      bus_out
);
  // ************************************************************
  // host register bus cycles
  // ************************************************************
  initial bus_out = '0;

  // one-cycle strobe; idle lines show inverted values so stale data never passes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    bus_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_in);
    bus_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    bus_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock_in);
    bus_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    #1;
    d = rdata_in;
  endtask

  // high byte at the lower offset, low byte last
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 8'h01, v[7:0]);
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    rd(a, v[15:8]);
    rd(a + 8'h01, v[7:0]);
  endtask

  task automatic wr32(input logic [31:0] v);
    wr16(ACC_B3_ADDR, v[31:16]);
    wr16(ACC_B1_ADDR, v[15:0]);
  endtask

  task automatic rd32(output logic [31:0] v);
    rd16(ACC_B3_ADDR, v[31:16]);
    rd16(ACC_B1_ADDR, v[15:0]);
  endtask
endmodule

// >>> math_coprocessor_control_tb.sv
`timescale 1ns/100ps
module math_coprocessor_control_tb;
  import mcc_pkg::*;
  logic         clock_in = 1'b0;
  logic         rst_in   = 1'b1;
  mcc_bus_req_t bus;
  logic [7:0]   rdata;
  logic         busy;
  int           num_errors = 0;
  int           tests_run  = 0;

  always #10 clock_in = ~clock_in;

  mcc_top dut_u (.clock_in(clock_in), .rst_in(rst_in), .bus_in(bus), .rdata_out(rdata), .busy_out(busy));
  mcc_host_model host_u (.clock_in(clock_in), .rdata_in(rdata), .bus_out(bus));

  // ************************************************************
  // checking helpers
  // ************************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_reg(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(a, d);
    chk(name, {24'h0, exp}, {24'h0, d});
  endtask

  task automatic chk_acc(input logic [31:0] exp);
    logic [31:0] v;
    host_u.rd32(v);
    chk("accumulator", exp, v);
  endtask

  task automatic chk_opb(input logic [15:0] exp);
    logic [15:0] v;
    host_u.rd16(OPB_HI_ADDR, v);
    chk("operand_b", {16'h0, exp}, {16'h0, v});
  endtask

  // busy samples over a fixed window starting at the request edge
  task automatic chk_busy(input int exp);
    int n;
    n = 0;
    repeat (20) begin
      #1;
      if (busy === 1'b1) n++;
      @(posedge clock_in);
    end
    chk("busy cycles", 32'(exp), 32'(n));
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    chk_reg("control", CTRL_ADDR, 8'h00);
    chk_reg("status", STAT_ADDR, 8'h00);
    $display("done reset");
  endtask

  task automatic t_mul();
    host_u.wr(CTRL_ADDR, 8'h00);
    host_u.wr16(OPA_HI_ADDR, 16'h1234);
    host_u.wr(OPB_HI_ADDR, 8'h00);
    chk_busy(0);
    host_u.wr(OPB_LO_ADDR, 8'h05);
    chk_busy(OP_CYCLES);
    chk_acc(32'h00005B04);
    chk_reg("status", STAT_ADDR, 8'h01);
    host_u.wr(CTRL_ADDR, 8'h80);
    host_u.wr16(OPA_HI_ADDR, 16'hFFFE);
    host_u.wr16(OPB_HI_ADDR, 16'h0003);
    chk_busy(OP_CYCLES);
    chk_acc(32'hFFFFFFFA);
    host_u.wr(STAT_ADDR, 8'h00);
    chk_reg("status", STAT_ADDR, 8'h81);
    host_u.wr(STAT_ADDR, 8'hF8);
    chk_reg("status", STAT_ADDR, 8'h81);
    host_u.wr(STAT_ADDR, 8'h01);
    chk_reg("status", STAT_ADDR, 8'h80);
    $display("done multiply");
  endtask

  task automatic t_ctrl();
    host_u.wr(CTRL_ADDR, 8'h87);
    chk_busy(0);
    chk_reg("control", CTRL_ADDR, 8'h80);
    host_u.wr(CTRL_ADDR, 8'h88);
    chk_busy(OP_CYCLES);
    chk_reg("control", CTRL_ADDR, 8'h80);
    $display("done control");
  endtask

  task automatic t_integer_divide_function();
    host_u.wr(CTRL_ADDR, 8'h40);
    host_u.wr(STAT_ADDR, 8'h07);
    host_u.wr32(32'd100);
    host_u.wr(OPB_LO_ADDR, 8'h09);
    chk_busy(0);
    host_u.wr16(OPA_HI_ADDR, 16'h0007);
    chk_busy(OP_CYCLES);
    chk_acc(32'h0000000E);
    chk_opb(16'h0002);
    chk_reg("status", STAT_ADDR, 8'h01);
    host_u.wr32(32'd21);
    host_u.wr(OPA_LO_ADDR, 8'h07);
    chk_busy(OP_CYCLES);
    chk_reg("status", STAT_ADDR, 8'h41);
    host_u.wr(STAT_ADDR, 8'h07);
    host_u.wr32(32'h00000055);
    host_u.wr16(OPA_HI_ADDR, 16'h0000);
    chk_busy(OP_CYCLES);
    chk_reg("status", STAT_ADDR, 8'h03);
    chk_acc(32'h00000055);
    host_u.wr(STAT_ADDR, 8'h02);
    chk_reg("status", STAT_ADDR, 8'h01);
    $display("done integer divide");
  endtask

  // same operands, compensation off then on
  task automatic t_comp();
    logic [7:0] ctl [2];
    logic [31:0] q [2];
    logic [15:0] r [2];
    ctl = '{8'hC0, 8'hD0};
    q = '{32'hFFFFFFFD, 32'hFFFFFFFC};
    r = '{16'hFFFF, 16'h0001};
    for (int i = 0; i < 2; i++) begin
      host_u.wr(CTRL_ADDR, ctl[i]);
      host_u.wr32(32'hFFFFFFF9);
      host_u.wr16(OPA_HI_ADDR, 16'h0002);
      chk_busy(OP_CYCLES);
      chk_acc(q[i]);
      chk_opb(r[i]);
    end
    $display("done compensation");
  endtask

  task automatic t_fractional_divide_function();
    host_u.wr(CTRL_ADDR, 8'h60);
    host_u.wr(STAT_ADDR, 8'h07);
    host_u.wr32(32'h00004000);
    host_u.wr16(OPA_HI_ADDR, 16'h8000);
    chk_busy(0);
    host_u.wr(CTRL_ADDR, 8'h68);
    chk_busy(OP_CYCLES);
    chk_acc(32'h40008000);
    chk_opb(16'h0000);
    chk_reg("status", STAT_ADDR, 8'h41);
    $display("done fractional divide");
  endtask

  task automatic t_mac();
    host_u.wr(CTRL_ADDR, 8'h20);
    host_u.wr(STAT_ADDR, 8'h07);
    host_u.wr32(32'hFFFFFFFF);
    host_u.wr16(OPA_HI_ADDR, 16'h0001);
    host_u.wr16(OPB_HI_ADDR, 16'h0001);
    chk_busy(OP_CYCLES);
    chk_acc(32'h00000000);
    chk_reg("status", STAT_ADDR, 8'h05);
    host_u.wr(STAT_ADDR, 8'h01);
    chk_reg("status", STAT_ADDR, 8'h04);
    host_u.wr(STAT_ADDR, 8'h04);
    chk_reg("status", STAT_ADDR, 8'h00);
    $display("done accumulate");
  endtask

  // a second start mid-run must restart the full count
  task automatic t_restart();
    host_u.wr(CTRL_ADDR, 8'h00);
    host_u.wr16(OPA_HI_ADDR, 16'h0002);
    host_u.wr(OPB_LO_ADDR, 8'h03);
    repeat (3) @(posedge clock_in);
    host_u.wr(OPB_LO_ADDR, 8'h04);
    chk_busy(OP_CYCLES);
    chk_acc(32'h00000008);
    $display("done restart");
  endtask

  // reset during a run must abort it and clear control and status
  task automatic t_midreset();
    host_u.wr(CTRL_ADDR, 8'hA8);
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    #1;
    chk("busy in reset", 32'h0, {31'h0, busy});
    chk("rdata in reset", 32'h0, {24'h0, rdata});
    @(posedge clock_in);
    rst_in <= 1'b0;
    chk_busy(0);
    chk_reg("control", CTRL_ADDR, 8'h00);
    chk_reg("status", STAT_ADDR, 8'h00);
    $display("done mid-run reset");
  endtask

  // ************************************************************
  // run control
  // ************************************************************
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // whole run is near 620 cycles; the limit leaves ample margin
  initial begin
    repeat (8000) @(posedge clock_in);
    num_errors++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    t_reset();
    t_mul();
    t_ctrl();
    t_integer_divide_function();
    t_comp();
    t_fractional_divide_function();
    t_mac();
    t_restart();
    t_midreset();
    summarize();
  end
endmodule
